// ===== common/uer_pkg.sv
package uer_pkg;
    // Stop bit setting
    localparam logic STOP_ONE = 1'h0;
    localparam logic STOP_TWO = 1'h1;
    // Parity modes
    localparam logic [2:0] PAR_NONE = 3'h0;
    localparam logic [2:0] PAR_ODD = 3'h1;
    localparam logic [2:0] PAR_EVEN = 3'h2;
    localparam logic [2:0] PAR_MARK = 3'h3;
    localparam logic [2:0] PAR_SPACE = 3'h4;
    // Line format
    localparam int DATA_MAX = 8;
    localparam logic [3:0] DATA_SEVEN = 4'h7;
    localparam logic [3:0] DATA_EIGHT = 4'h8;
    // Bit time in clocks less one (default baud div)
    localparam logic [15:0] DIV_DEFAULT = 16'h00D9;

    // Line configuration
    typedef struct packed {
        logic [15:0] div;
        logic eight_bits;
        logic two_stop;
        logic [2:0] parity;
    } uer_cfg_t;

    // Received character with status
    typedef struct packed {
        logic [7:0] data;
        logic frame_err;
        logic parity_err;
    } uer_char_t;
endpackage

// ===== logic/uer_sync.sv
// Two-flop synchroniser for the receive pin, idles high
module uer_sync (
    input wire logic clock,
    input wire logic reset,
    input wire logic din,
    output logic dout
);
    logic first_r;
    logic second_r;
    // First stage is read only by the second
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            first_r <= 1'h1;
            second_r <= 1'h1;
        end else begin
            first_r <= din;
            second_r <= first_r;
        end
    end
    assign dout = second_r;
endmodule

// ===== logic/uer_rx.sv
// Functional notes
// - One stop bit: framing error never reported
// - Other stop counts: framing error detected, reported
// - Mark/space parity: parity error never reported
// - Odd/even parity: mismatch flags parity error
module uer_rx (
    input wire logic clock,
    input wire logic reset,
    input wire logic rx_pin,
    input wire uer_pkg::uer_cfg_t cfg,
    output logic out_valid,
    output uer_pkg::uer_char_t out_char
);
    import uer_pkg::*;

    // Receiver states, one-hot
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_START = 5'h02,
        S_DATA = 5'h04,
        S_PAR = 5'h08,
        S_STOP = 5'h10
    } uer_state_t;

    // Parity of data bits, odd sense
    // Bit 7 is left out of seven-bit frames, where it is zero-filled
    function automatic logic xor_bits(input logic [7:0] d, input logic eight);
        xor_bits = eight ? ^d : ^d[6:0];
    endfunction

    logic rx; // Synchronised line
    uer_state_t state_r, state_nxt;
    logic [15:0] cnt_r, cnt_nxt; // Clocks inside a bit
    logic [3:0] bit_r, bit_nxt; // Bits taken in this phase
    logic [7:0] shift_r, shift_nxt; // Data assembly
    logic par_bad_r, par_bad_nxt; // Parity mismatch seen
    logic frm_bad_r, frm_bad_nxt; // Bad stop seen
    logic valid_r, valid_nxt; // Character done pulse
    logic rx_prev_r, rx_prev_nxt; // Synchronised line one clock ago
    uer_char_t char_r, char_nxt;
    logic [15:0] half;
    logic at_mid;
    logic [3:0] nbits;

    // Pin crosses into clock domain
    uer_sync u_sync (
        .clock(clock),
        .reset(reset),
        .din(rx_pin),
        .dout(rx)
    );

    // Half of div (bit time less one), rounded down; the start recheck lands near mid-bit
    assign half = {1'h0, cfg.div[15:1]};
    // Bit period is div+1 clocks, so sample when the count reaches div
    assign at_mid = (cnt_r == cfg.div);
    // Data length of the current frame
    assign nbits = cfg.eight_bits ? DATA_EIGHT : DATA_SEVEN;

    // Next-state logic for the receiver
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 16'h0001;
        bit_nxt = bit_r;
        shift_nxt = shift_r;
        par_bad_nxt = par_bad_r;
        frm_bad_nxt = frm_bad_r;
        valid_nxt = 1'h0;
        char_nxt = char_r;
        rx_prev_nxt = rx;
        unique case (state_r)
            // Wait for a falling edge, not a low level: a line still low
            // after a bad stop bit must not open a phantom frame
            S_IDLE: begin
                cnt_nxt = 16'h0000;
                if (rx_prev_r && !rx) begin
                    state_nxt = S_START;
                end
            end
            // Recheck start at mid bit; glitches are dropped
            S_START: begin
                if (cnt_r == half) begin
                    // Fresh flags, so errors pair only with this character
                    cnt_nxt = 16'h0000;
                    bit_nxt = 4'h0;
                    par_bad_nxt = 1'h0;
                    frm_bad_nxt = 1'h0;
                    shift_nxt = 8'h00;
                    state_nxt = rx ? S_IDLE : S_DATA;
                end
            end
            // LSB first
            S_DATA: begin
                if (at_mid) begin
                    cnt_nxt = 16'h0000;
                    shift_nxt = cfg.eight_bits ? {rx, shift_r[7:1]}
                                               : {1'h0, rx, shift_r[6:1]};
                    bit_nxt = bit_r + 4'h1;
                    if (bit_r + 4'h1 == nbits) begin
                        bit_nxt = 4'h0;
                        state_nxt = (cfg.parity == PAR_NONE) ? S_STOP : S_PAR;
                    end
                end
            end
            // Parity bit; fixed-value modes are not checked
            S_PAR: begin
                if (at_mid) begin
                    cnt_nxt = 16'h0000;
                    if (cfg.parity == PAR_ODD) begin
                        par_bad_nxt = (xor_bits(shift_r, cfg.eight_bits) ^ rx) != 1'h1;
                    end else if (cfg.parity == PAR_EVEN) begin
                        par_bad_nxt = (xor_bits(shift_r, cfg.eight_bits) ^ rx) != 1'h0;
                    end else begin
                        par_bad_nxt = 1'h0;
                    end
                    state_nxt = S_STOP;
                end
            end
            // Stop bits; only multi-stop frames report a bad stop
            S_STOP: begin
                if (at_mid) begin
                    cnt_nxt = 16'h0000;
                    if (cfg.two_stop && !rx) begin
                        frm_bad_nxt = 1'h1;
                    end
                    bit_nxt = bit_r + 4'h1;
                    if (!cfg.two_stop || bit_r == 4'h1) begin
                        // Data and its flags leave together
                        valid_nxt = 1'h1;
                        char_nxt.data = shift_r;
                        char_nxt.parity_err = par_bad_r;
                        char_nxt.frame_err = cfg.two_stop && (frm_bad_r || !rx);
                        state_nxt = S_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    // Receiver registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_r <= S_IDLE;
            cnt_r <= 16'h0000;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            par_bad_r <= 1'h0;
            frm_bad_r <= 1'h0;
            valid_r <= 1'h0;
            char_r <= '0;
            // Idle level, so no false start edge follows reset
            rx_prev_r <= 1'h1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            shift_r <= shift_nxt;
            par_bad_r <= par_bad_nxt;
            frm_bad_r <= frm_bad_nxt;
            valid_r <= valid_nxt;
            char_r <= char_nxt;
            // Line history for the start-edge detector
            rx_prev_r <= rx_prev_nxt;
        end
    end

    // Outputs come straight from flip-flops
    assign out_valid = valid_r;
    assign out_char = char_r;

    // Checks
    one_stop_frm_a: assert property (@(posedge clock) disable iff (reset)
        out_valid && !cfg.two_stop |-> !out_char.frame_err)
        else $error("framing error with one stop bit");
    two_stop_frm_a: assert property (@(posedge clock) disable iff (reset)
        state_r == S_STOP && at_mid && cfg.two_stop && bit_r == 4'h1 && !rx
        |=> out_valid && out_char.frame_err)
        else $error("missed framing error");
    fixed_par_a: assert property (@(posedge clock) disable iff (reset)
        out_valid && (cfg.parity == PAR_MARK || cfg.parity == PAR_SPACE)
        |-> !out_char.parity_err)
        else $error("parity error in mark or space mode");
    even_par_a: assert property (@(posedge clock) disable iff (reset)
        state_r == S_PAR && at_mid && cfg.parity == PAR_EVEN
        |=> par_bad_r == $past(xor_bits(shift_r, cfg.eight_bits) ^ rx))
        else $error("even parity check wrong");
    odd_par_a: assert property (@(posedge clock) disable iff (reset)
        state_r == S_PAR && at_mid && cfg.parity == PAR_ODD
        |=> par_bad_r == !$past(xor_bits(shift_r, cfg.eight_bits) ^ rx))
        else $error("odd parity check wrong");
    err_with_data_a: assert property (@(posedge clock) disable iff (reset)
        state_r == S_STOP ##1 state_r == S_IDLE |-> out_valid && out_char.data == $past(shift_r))
        else $error("data and status not delivered together");
    valid_pulse_a: assert property (@(posedge clock) disable iff (reset)
        out_valid |=> !out_valid)
        else $error("valid longer than one cycle");
    no_par_err_a: assert property (@(posedge clock) disable iff (reset)
        out_valid && cfg.parity == PAR_NONE |-> !out_char.parity_err)
        else $error("parity error with no parity");

    // Stop-bit paths, character hold and per-character flag clearing
    first_stop_frm_a: assert property (@(posedge clock) disable iff (reset)
        state_r == S_STOP && at_mid && cfg.two_stop && bit_r == 4'h0 && !rx |=> frm_bad_r)
        else $error("bad first stop bit not held");
    one_stop_bad_a: assert property (@(posedge clock) disable iff (reset)
        state_r == S_STOP && at_mid && !cfg.two_stop && !rx |=> out_valid && !out_char.frame_err)
        else $error("bad single stop bit reported");
    char_hold_a: assert property (@(posedge clock) disable iff (reset)
        $changed(out_char) |-> out_valid)
        else $error("character changed without valid");
    flag_clear_a: assert property (@(posedge clock) disable iff (reset)
        state_r == S_START && cnt_r == half |=> !frm_bad_r && !par_bad_r)
        else $error("stale error flag carried into next character");

    // Scenario coverage
    cov_frame_c: cover property (@(posedge clock) out_valid && out_char.frame_err);
    cov_par_c: cover property (@(posedge clock) out_valid && out_char.parity_err);
    cov_clean_c: cover property (@(posedge clock) out_valid && !out_char.parity_err);
    cov_two_stop_c: cover property (@(posedge clock) out_valid && cfg.two_stop);
    cov_fixed_par_c: cover property (@(posedge clock) out_valid && cfg.parity == PAR_SPACE);
endmodule

// ===== bench/uer_line_model.sv
// Far-end serial sender, idles high between frames
module uer_line_model
    import uer_pkg::*;
(
    input wire logic clock,
    input wire uer_pkg::uer_cfg_t cfg,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line = 1'b1;
    // One bit time, entered and left just after an edge
    task automatic hold_bit(input logic v);
        line = v;
        repeat (int'(cfg.div) + 1) @(posedge clock);
        #1;
    endtask
    // Whole frame, LSB first, optional parity and stop faults
    task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        logic [7:0] dm;
        logic par;
        dm = cfg.eight_bits ? d : {1'b0, d[6:0]};
        case (cfg.parity)
            PAR_ODD: par = ~^dm;
            PAR_EVEN: par = ^dm;
            PAR_MARK: par = 1'b1;
            default: par = 1'b0;
        endcase
        @(posedge clock);
        #1;
        hold_bit(1'b0);
        for (int i = 0; i < (cfg.eight_bits ? 8 : 7); i++) hold_bit(dm[i]);
        if (cfg.parity != PAR_NONE) hold_bit(par ^ bad_par);
        // A bad stop is the first one; line then rests high so no false start
        hold_bit(~bad_stop);
        if (cfg.two_stop) hold_bit(1'b1);
        if (bad_stop) hold_bit(1'b1);
    endtask
endmodule

// ===== bench/testbench.sv
// Self-checking bench: driver queues notes, monitor pops them
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import uer_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    uer_cfg_t cfg;
    logic rx_pin;
    logic out_valid;
    uer_char_t out_char;
    uer_char_t exp_q[$];
    uer_char_t exp_c;
    uer_char_t e;
    logic [7:0] d;
    int num_errors = 0;
    int n_tests = 0;
    int seed = 32'hebf5;
    logic [2:0] modes [5] = '{PAR_NONE, PAR_ODD, PAR_EVEN, PAR_MARK, PAR_SPACE};
    // 25 MHz clock
    always #20 clock = ~clock;
    uer_rx i_dut (.clock(clock), .reset(reset), .rx_pin(rx_pin), .cfg(cfg),
        .out_valid(out_valid), .out_char(out_char));
    uer_line_model i_line (.clock(clock), .cfg(cfg), .line(rx_pin));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Monitor: looks mid-cycle, away from the edge that launches the outputs
    always @(negedge clock) begin
        if (out_valid === 1'b1) begin
            check("queued", 8'(exp_q.size() != 0), 8'h01);
            if (exp_q.size() != 0) begin
                exp_c = exp_q.pop_front();
                check("data", out_char.data, exp_c.data);
                check("frame_err", {7'h00, out_char.frame_err}, {7'h00, exp_c.frame_err});
                check("parity_err", {7'h00, out_char.parity_err}, {7'h00, exp_c.parity_err});
            end
        end
    end
    // Watchdog well past the expected run length
    initial begin
        #2000000;
        num_errors++;
        $display("watchdog expired");
        complete_run();
    end
    // Every parity mode with both stop counts, each fault mix back to back
    initial begin
        cfg = '0;
        cfg.div = 16'h0009;
        repeat (6) @(posedge clock);
        #1 reset = 1'b0;
        repeat (3) @(posedge clock);
        for (int m = 0; m < 5; m++) begin
            for (int s = 0; s < 2; s++) begin
                @(posedge clock);
                #1;
                cfg.parity = modes[m];
                cfg.two_stop = s[0];
                cfg.eight_bits = 1'($random(seed));
                for (int k = 0; k < 4; k++) begin
                    d = 8'($random(seed));
                    e.data = cfg.eight_bits ? d : {1'b0, d[6:0]};
                    e.frame_err = k[1] & cfg.two_stop;
                    e.parity_err = k[0] & (cfg.parity == PAR_ODD || cfg.parity == PAR_EVEN);
                    exp_q.push_back(e);
                    i_line.send(d, k[0], k[1]);
                end
                // Config changes once the last character is out, or after 100 clocks
                for (int w = 0; w < 100 && exp_q.size() != 0; w++) @(posedge clock);
                check("pending", 8'(exp_q.size()), 8'h00);
                exp_q.delete();
                $display("test parity %0d stops %0d done", m, s + 1);
            end
        end
        complete_run();
    end
endmodule
